// file: hdl/flash_program_erase_status.sv
// Behaviour
// - while programming, polled bit 7 reads inverse of data bit 7
// - status valid after 4th program or 6th erase write; poll target address
// - polled bit 7 reads zero during erase, stored value afterwards
// - program to a protected sector is ignored, array unchanged
// - all-protected erase: polled bit zero about 100us, nothing erased
// - toggle bit inverts on every status read while busy with a select high, except in the all-protected wait
// - toggling stops at cycle end; reads return array data again
// - all-protected erase: toggle bit reads zero about 100us
// - failure flag zero normally, set on program or erase failure
// - failure flag set on zero-to-one program attempt or program time-out
// - failure flag cleared only by the reset-flash command
// - erase window flag zero for window after sector erase, then one
// - erase writes FFh per sector or whole array; program only clears bits
// - during erase failure flag means time-out; readable in erased sector
// - fast-program mode entered by two unlock writes then 20h
// - fast program: A0h write then address and data write, no unlock
// - in fast-program mode only program and exit commands accepted
// - fast-program mode left by 90h then 00h at any address
// - unlock is AAh at 555h then 55h at AAAh
// - primary array on any primary select, secondary on any secondary select
`include "flash_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_program_erase_status
    import flash_pkg::*;
#(
    parameter int AW       = 8,
    parameter int PROG_CYC = `PROG_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        wr_strobe,
    input  wire logic        rd_strobe,
    output logic      [7:0]  rd_data,
    input  wire logic [7:0]  primary_sector_selects,
    input  wire logic [3:0]  secondary_sector_selects,
    input  wire logic [11:0] sector_protect,
    input  wire logic        algo_fault,
    output logic             busy,
    output logic             failure_flag,
    output logic             erase_window_flag
);
    localparam int MW = `SEC_W + AW;
    localparam logic [`CNT_W-1:0] WIN_LAST  = `CNT_W'(`WINDOW_CYC - 1);
    localparam logic [`CNT_W-1:0] PROT_LAST = `CNT_W'(`PROT_CYC - 1);
    localparam logic [`CNT_W-1:0] PROG_LAST = `CNT_W'(PROG_CYC - 1);

    function automatic logic [`SEC_W-1:0] first_set(input logic [11:0] v);
        logic [`SEC_W-1:0] r;
        r = '0;
        for (int i = 11; i >= 0; i--) begin
            if (v[i]) begin
                r = `SEC_W'(i);
            end
        end
        return r;
    endfunction : first_set

    function automatic logic hit(input logic [7:0]  d,
                                 input logic [11:0] a,
                                 input logic [7:0]  code,
                                 input logic [11:0] ua);
        return (d == code) && (a == ua);
    endfunction : hit

    cmd_state_t        cmd_q, cmd_d;
    eng_state_t        eng_q, eng_d;
    logic [`CNT_W-1:0] cnt_q, cnt_d;
    logic [MW-1:0]     sw_q, sw_d;
    logic [11:0]       mask_q, mask_d;
    logic [MW-1:0]     prog_addr_q;
    logic [7:0]        prog_data_q;
    logic              op_prog_q;
    logic              bulk_q;
    logic              failure_q;
    logic              toggle_q;
    logic              show_q;
    logic [7:0]        status_q;
    logic              go_prog;
    logic              go_sect;
    logic              go_bulk;
    logic              fail_set;

    cell_bus_if #(.AW(MW)) cbus ();

    flash_cells #(.AW(MW)) u_cells (
        .clk   (clk),
        .reset (reset),
        .bus   (cbus)
    );

    // sector decode
    wire [11:0]       sel      = {secondary_sector_selects, primary_sector_selects};
    wire              sel_any  = |sel;
    wire [`SEC_W-1:0] cur_sec  = first_set(sel);
    wire [MW-1:0]     cur_addr = {cur_sec, addr[AW-1:0]};
    wire [11:0]       cur_bit  = 12'(1) << cur_sec;
    wire [11:0]       bulk_msk = (|primary_sector_selects) ? `PRIMARY_MASK
                                                           : `SECONDARY_MASK;
    wire              wv       = wr_strobe & sel_any;
    wire              rv       = rd_strobe & sel_any;

    // command decode
    wire w_un1   = wv & hit(wr_data, addr[11:0], `CMD_UNLOCK1, `ADDR_UNLOCK1);
    wire w_un2   = wv & hit(wr_data, addr[11:0], `CMD_UNLOCK2, `ADDR_UNLOCK2);
    wire w_reset = wv & (wr_data == `CMD_RESET);
    wire w_sect  = wv & (wr_data == `CMD_SECTOR_ERASE);
    wire w_bulk  = hit(wr_data, addr[11:0], `CMD_BULK_ERASE, `ADDR_UNLOCK1);

    wire idle    = (eng_q == ENG_IDLE);
    wire prog_ok = go_prog & ~sector_protect[cur_sec];
    wire [15:0] live_msk  = {4'h0, mask_q & ~sector_protect};
    wire        sect_none = ((mask_q & ~sector_protect) == 12'h000);
    wire        bulk_none = ((bulk_msk & ~sector_protect) == 12'h000);
    wire        erase_hit = live_msk[sw_q[MW-1 -: `SEC_W]];
    wire        sweep_end = (sw_q == {MW{1'b1}});
    wire        bad_bits  = |(prog_data_q & ~cbus.rdata);

    // command sequencer, advances only while the engine is idle; reset-flash in the fail state returns it to idle
    always_comb begin
        cmd_d   = cmd_q;
        go_prog = 1'b0;
        go_sect = 1'b0;
        go_bulk = 1'b0;
        if (idle && wv) begin
            case (cmd_q)
                CMD_IDLE: begin
                    if (w_un1) cmd_d = CMD_U1;
                end
                CMD_U1: begin
                    cmd_d = w_un2 ? CMD_U2 : CMD_IDLE;
                end
                CMD_U2: begin
                    if (wr_data == `CMD_PROGRAM) begin
                        cmd_d = CMD_PADDR;
                    end else if (wr_data == `CMD_ERASE_SETUP) begin
                        cmd_d = CMD_ESET;
                    end else if (wr_data == `CMD_BYPASS) begin
                        cmd_d = CMD_BYP;
                    end else begin
                        cmd_d = CMD_IDLE;
                    end
                end
                CMD_PADDR: begin
                    go_prog = 1'b1;
                    cmd_d   = CMD_IDLE;
                end
                CMD_ESET: begin
                    cmd_d = w_un1 ? CMD_EU1 : CMD_IDLE;
                end
                CMD_EU1: begin
                    cmd_d = w_un2 ? CMD_EU2 : CMD_IDLE;
                end
                CMD_EU2: begin
                    go_sect = w_sect;
                    go_bulk = w_bulk;
                    cmd_d   = CMD_IDLE;
                end
                CMD_BYP: begin
                    if (wr_data == `CMD_PROGRAM) begin
                        cmd_d = CMD_BYP_PADDR;
                    end else if (wr_data == `CMD_BYPASS_EXIT1) begin
                        cmd_d = CMD_BYP_EXIT;
                    end else begin
                        cmd_d = CMD_BYP;
                    end
                end
                CMD_BYP_PADDR: begin
                    go_prog = 1'b1;
                    cmd_d   = CMD_BYP;
                end
                CMD_BYP_EXIT: begin
                    cmd_d = (wr_data == `CMD_BYPASS_EXIT2) ? CMD_IDLE
                                                           : CMD_BYP;
                end
                default: cmd_d = CMD_IDLE;
            endcase
        end else if (eng_q == ENG_FAIL && w_reset) begin
            cmd_d = CMD_IDLE;
        end
    end

    // embedded algorithm
    always_comb begin
        eng_d    = eng_q;
        cnt_d    = cnt_q;
        sw_d     = '0;
        mask_d   = mask_q;
        fail_set = 1'b0;
        case (eng_q)
            ENG_IDLE: begin
                cnt_d = '0;
                if (prog_ok) begin
                    eng_d = ENG_PROG_RD;
                end else if (go_sect) begin
                    eng_d  = ENG_WINDOW;
                    mask_d = cur_bit;
                end else if (go_bulk) begin
                    mask_d = bulk_msk;
                    eng_d  = bulk_none ? ENG_PROT : ENG_ERASE;
                end
            end
            ENG_WINDOW: begin
                if (w_sect) begin
                    mask_d = mask_q | cur_bit;
                    cnt_d  = '0;
                end else if (wv) begin
                    eng_d  = ENG_IDLE;
                    mask_d = '0;
                end else if (cnt_q == WIN_LAST) begin
                    cnt_d = '0;
                    eng_d = sect_none ? ENG_PROT : ENG_ERASE;
                end else begin
                    cnt_d = cnt_q + `CNT_W'(1);
                end
            end
            ENG_PROG_RD: begin
                eng_d = ENG_PROG_WR;
            end
            ENG_PROG_WR: begin
                fail_set = bad_bits;
                eng_d    = bad_bits ? ENG_FAIL : ENG_PROG_WAIT;
            end
            ENG_PROG_WAIT: begin
                if (algo_fault) begin
                    fail_set = 1'b1;
                    eng_d    = ENG_FAIL;
                end else if (cnt_q == PROG_LAST) begin
                    eng_d = ENG_IDLE;
                end else begin
                    cnt_d = cnt_q + `CNT_W'(1);
                end
            end
            ENG_ERASE: begin
                sw_d = sw_q + MW'(1);
                if (w_reset && !bulk_q) begin
                    eng_d = ENG_IDLE;
                end else if (algo_fault) begin
                    fail_set = 1'b1;
                    eng_d    = ENG_FAIL;
                end else if (sweep_end) begin
                    eng_d = ENG_IDLE;
                end
            end
            ENG_PROT: begin
                if (cnt_q == PROT_LAST) begin
                    eng_d = ENG_IDLE;
                end else begin
                    cnt_d = cnt_q + `CNT_W'(1);
                end
            end
            ENG_FAIL: begin
                if (w_reset) eng_d = ENG_IDLE;
            end
            default: eng_d = ENG_IDLE;
        endcase
    end

    // cell port: engine owns it in the program read and write steps and while erasing
    wire eng_prog = (eng_q == ENG_PROG_RD) || (eng_q == ENG_PROG_WR);
    wire eng_ers  = (eng_q == ENG_ERASE);
    assign cbus.addr  = eng_prog ? prog_addr_q : (eng_ers ? sw_q : cur_addr);
    assign cbus.we    = (eng_q == ENG_PROG_WR) || (eng_ers && erase_hit);
    assign cbus.wdata = eng_ers ? `ERASED_BYTE
                                : (cbus.rdata & prog_data_q);

    // status byte fields
    wire poll_bit = op_prog_q ? ~prog_data_q[7] : 1'b0;
    wire tog_bit  = (eng_q == ENG_PROT) ? 1'b0 : toggle_q;
    wire win_bit  = (eng_q != ENG_WINDOW);
    wire prot_pol = (eng_q == ENG_PROT) ? 1'b0 : poll_bit;
    wire [7:0] status_byte = {prot_pol, tog_bit, failure_q, 1'b0,
                              win_bit, 3'b000};
    wire fail_clr = w_reset && (idle || eng_q == ENG_FAIL);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd_q <= CMD_IDLE;
            eng_q <= ENG_IDLE;
            cnt_q <= '0;
            sw_q  <= '0;
            mask_q <= '0;
        end else begin
            cmd_q <= cmd_d;
            eng_q <= eng_d;
            cnt_q <= cnt_d;
            sw_q  <= sw_d;
            mask_q <= mask_d;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prog_addr_q <= '0;
            prog_data_q <= 8'h00;
            op_prog_q   <= 1'b0;
            bulk_q      <= 1'b0;
        end else if (idle && (prog_ok || go_sect || go_bulk)) begin
            prog_addr_q <= cur_addr;
            prog_data_q <= wr_data;
            op_prog_q   <= prog_ok;
            bulk_q      <= go_bulk;
        end
    end

    // set wins over the reset-flash clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            failure_q <= 1'b0;
        end else begin
            failure_q <= fail_set | (failure_q & ~fail_clr);
        end
    end

    // host read: status while the engine is busy, cell data otherwise
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            show_q   <= 1'b0;
            status_q <= 8'h00;
            toggle_q <= 1'b0;
        end else if (rv) begin
            show_q   <= !idle;
            status_q <= status_byte;
            if (!idle && eng_q != ENG_PROT) begin
                toggle_q <= ~toggle_q;
            end
        end else begin
            show_q <= 1'b0;
        end
    end

    assign rd_data           = show_q ? status_q : cbus.rdata;
    assign busy              = !idle;
    assign failure_flag      = failure_q;
    assign erase_window_flag = win_bit;
endmodule : flash_program_erase_status

`default_nettype wire

// file: hdl/flash_consts.svh
`ifndef FLASH_CONSTS_SVH
`define FLASH_CONSTS_SVH

// command codes and unlock addresses
`define CMD_UNLOCK1      8'hAA
`define CMD_UNLOCK2      8'h55
`define ADDR_UNLOCK1     12'h555
`define ADDR_UNLOCK2     12'hAAA
`define CMD_PROGRAM      8'hA0
`define CMD_ERASE_SETUP  8'h80
`define CMD_SECTOR_ERASE 8'h30
`define CMD_BULK_ERASE   8'h10
`define CMD_BYPASS       8'h20
`define CMD_BYPASS_EXIT1 8'h90
`define CMD_BYPASS_EXIT2 8'h00
`define CMD_RESET        8'hF0
`define ERASED_BYTE      8'hFF

// sectors: primary 0..7, secondary 8..11
`define N_SECTORS        12
`define SEC_W            4
`define PRIMARY_MASK     12'h0FF
`define SECONDARY_MASK   12'hF00

// timing
`define CLK_MHZ          25
`define WINDOW_US        100
`define WINDOW_CYC       (`WINDOW_US * `CLK_MHZ)
`define PROT_US          100
`define PROT_CYC         (`PROT_US * `CLK_MHZ)
`define PROG_CYC         16
`define CNT_W            12

`endif

// file: hdl/flash_pkg.sv
package flash_pkg;

    typedef enum logic [3:0] {
        CMD_IDLE,
        CMD_U1,
        CMD_U2,
        CMD_PADDR,
        CMD_ESET,
        CMD_EU1,
        CMD_EU2,
        CMD_BYP,
        CMD_BYP_PADDR,
        CMD_BYP_EXIT
    } cmd_state_t;

    typedef enum logic [2:0] {
        ENG_IDLE,
        ENG_WINDOW,
        ENG_PROG_RD,
        ENG_PROG_WR,
        ENG_PROG_WAIT,
        ENG_ERASE,
        ENG_PROT,
        ENG_FAIL
    } eng_state_t;

endpackage : flash_pkg

// file: hdl/cell_bus_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cell_bus_if #(parameter int AW = 12);
    logic [AW-1:0] addr;
    logic [7:0]    wdata;
    logic          we;
    logic [7:0]    rdata;

    modport engine (output addr, output wdata, output we, input rdata);
    modport mem    (input addr, input wdata, input we, output rdata);
endinterface : cell_bus_if

`default_nettype wire

// file: hdl/flash_cells.sv
`timescale 1ns/1ps
`default_nettype none

module flash_cells #(
    parameter int AW = 12
) (
    input  wire logic  clk,
    input  wire logic  reset,
    cell_bus_if.mem    bus
);
    logic [7:0] cells [0:(1<<AW)-1];
    logic [7:0] rdata_q;

    always_ff @(posedge clk) begin
        if (bus.we) begin
            cells[bus.addr] <= bus.wdata;
        end
    end

    // read data registered; a write shows up on the next read
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= cells[bus.addr];
        end
    end

    assign bus.rdata = rdata_q;
endmodule : flash_cells

`default_nettype wire

// file: sim/mcu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_consts.svh"

module mcu_bus_model (
    input  wire logic        clk,
    input  wire logic [7:0]  rd_data,
    output logic      [15:0] addr,
    output logic      [7:0]  wr_data,
    output logic             wr_strobe,
    output logic             rd_strobe
);
    initial begin
        addr = 16'hFFFF;
        wr_data = 8'hFF;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
    end

    // released lines show the inverse so stale values never pass
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
        addr <= ~a;
        wr_data <= ~d;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        addr <= ~a;
        #1;
        d = rd_data;
    endtask : rd

    task automatic unlock();
        wr({4'h0, `ADDR_UNLOCK1}, `CMD_UNLOCK1);
        wr({4'h0, `ADDR_UNLOCK2}, `CMD_UNLOCK2);
    endtask : unlock
endmodule : mcu_bus_model
`default_nettype wire

// file: sim/flash_status_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_consts.svh"

module flash_status_sva
    import flash_pkg::*;
#(
    parameter int PROG_CYC = 16
) (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic [7:0] wr_data,
    input wire logic       wr_strobe,
    input wire logic       rd_strobe,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] primary_sector_selects,
    input wire logic [3:0] secondary_sector_selects,
    input wire logic       busy,
    input wire logic       failure_flag,
    input wire logic       erase_window_flag
);
    localparam int WIN_MIN = 2500;
    localparam int WIN_MAX = 3000;
    logic [11:0] win_cnt_q;
    logic [11:0] win_cnt_d;
    logic [11:0] bsy_cnt_q;
    logic [11:0] bsy_cnt_d;
    wire any_sel = (|primary_sector_selects) || (|secondary_sector_selects);
    wire sel_wr = wr_strobe && any_sel;
    wire clr_wr = sel_wr && (wr_data == `CMD_RESET);
    // any taken write restarts or aborts the window, so the count starts over
    assign win_cnt_d = (erase_window_flag || sel_wr) ? 12'h000 : win_cnt_q + 12'h001;
    assign bsy_cnt_d = !busy ? 12'h000 : (&bsy_cnt_q) ? bsy_cnt_q : bsy_cnt_q + 12'h001;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            win_cnt_q <= 12'h000;
            bsy_cnt_q <= 12'h000;
        end else begin
            win_cnt_q <= win_cnt_d;
            bsy_cnt_q <= bsy_cnt_d;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_sel_read;
        rd_strobe && any_sel;
    endsequence

    property p_reset_state;
        $fell(reset) |-> !busy && !failure_flag && erase_window_flag && rd_data == 8'h00;
    endproperty
    property p_fail_clear;
        $fell(failure_flag) |-> $past(clr_wr);
    endproperty
    property p_fail_rise;
        $rose(failure_flag) |-> busy;
    endproperty
    property p_fail_status;
        s_sel_read ##0 (busy && failure_flag) |=> rd_data[5];
    endproperty
    property p_window_len;
        $rose(erase_window_flag) && !$past(reset) |->
            (win_cnt_q >= WIN_MIN && win_cnt_q <= WIN_MAX) || $past(sel_wr);
    endproperty
    property p_window_max;
        !erase_window_flag |-> win_cnt_q <= WIN_MAX;
    endproperty
    property p_busy_cause;
        $rose(busy) |-> $past(sel_wr);
    endproperty
    property p_erase_status;
        s_sel_read ##0 !erase_window_flag |=> rd_data[7] == 1'b0 && rd_data[3] == 1'b0;
    endproperty
    property p_busy_len;
        $fell(busy) |-> bsy_cnt_q >= PROG_CYC + 1 || $past(sel_wr);
    endproperty

    a_reset_state: assert property (p_reset_state)
        else $error("bad state after reset");
    a_fail_clear: assert property (p_fail_clear)
        else $error("failure flag cleared without reset command");
    a_fail_rise: assert property (p_fail_rise)
        else $error("failure flag set while idle");
    a_fail_status: assert property (p_fail_status)
        else $error("status read lost failure bit");
    a_window_len: assert property (p_window_len)
        else $error("erase window length wrong");
    a_window_max: assert property (p_window_max)
        else $error("erase window overran");
    a_busy_cause: assert property (p_busy_cause)
        else $error("engine started without a write");
    a_erase_status: assert property (p_erase_status)
        else $error("status bits wrong in erase window");
    a_busy_len: assert property (p_busy_len)
        else $error("operation ended too early");
endmodule : flash_status_sva

bind flash_program_erase_status flash_status_sva #(.PROG_CYC(PROG_CYC)) u_sva (
    .clk(clk), .reset(reset), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data),
    .primary_sector_selects(primary_sector_selects),
    .secondary_sector_selects(secondary_sector_selects),
    .busy(busy), .failure_flag(failure_flag), .erase_window_flag(erase_window_flag)
);
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_consts.svh"

module tb_top;
    localparam int PCYC = 12;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [15:0] addr;
    logic [7:0]  wr_data;
    logic        wr_strobe;
    logic        rd_strobe;
    logic [7:0]  rd_data;
    logic [7:0]  psel = 8'h00;
    logic [3:0]  ssel = 4'h0;
    logic [11:0] prot = 12'h000;
    logic        fault = 1'b0;
    logic        busy;
    logic        failure_flag;
    logic        erase_window_flag;
    logic [7:0]  v1;
    logic [7:0]  v2;
    logic [7:0]  d;
    int          n;
    int          failures = 0;
    int          checks = 0;

    always #20 clk = ~clk;

    mcu_bus_model mcu (.clk(clk), .rd_data(rd_data), .addr(addr), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe));

    flash_program_erase_status #(.AW(4), .PROG_CYC(PCYC)) dut (
        .clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
        .primary_sector_selects(psel), .secondary_sector_selects(ssel),
        .sector_protect(prot), .algo_fault(fault), .busy(busy),
        .failure_flag(failure_flag), .erase_window_flag(erase_window_flag));

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic drive(input logic [7:0] p, input logic [3:0] s, input logic [11:0] pr,
                         input logic f);
        @(posedge clk);
        psel <= p;
        ssel <= s;
        prot <= pr;
        fault <= f;
    endtask : drive

    task automatic settle(input int cyc);
        repeat (cyc) @(posedge clk);
        #1;
    endtask : settle

    // n counts the cycles until busy drops, or until the window flag rises
    task automatic wait_until(input logic win);
        n = 0;
        do begin
            settle(1);
            n++;
        end while ((win ? erase_window_flag !== 1'b1 : busy !== 1'b0) && n < 20000);
        check("wait_limit", 8'h00, {7'h00, n >= 20000});
    endtask : wait_until

    task automatic rd_chk(input string name, input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] v;
        mcu.rd(a, v);
        check(name, exp, v);
    endtask : rd_chk

    task automatic prog(input logic [15:0] a, input logic [7:0] dd);
        mcu.unlock();
        mcu.wr(16'h0555, `CMD_PROGRAM);
        mcu.wr(a, dd);
    endtask : prog

    task automatic erase(input logic [15:0] a, input logic [7:0] code);
        mcu.unlock();
        mcu.wr(16'h0555, `CMD_ERASE_SETUP);
        mcu.unlock();
        mcu.wr(a, code);
    endtask : erase

    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    initial begin
        settle(2);
        check("rst_flags", 8'h01, {5'h00, busy, failure_flag, erase_window_flag});
        check("rst_rdata", 8'h00, rd_data);
        repeat (14) @(posedge clk);
        reset <= 1'b0;
        for (int g = 0; g < 2; g++) begin
            drive(g ? 8'h00 : 8'h01, g ? 4'h1 : 4'h0, 12'h000, 1'b0);
            d = g ? 8'h81 : 8'h5A;
            erase(16'h0555, `CMD_BULK_ERASE);
            mcu.rd(16'h0003, v1);
            check("bulk_poll", 8'h00, v1 & 8'h80);
            wait_until(1'b0);
            rd_chk("bulk_data", 16'h0003, `ERASED_BYTE);
            prog(16'h0003, d);
            mcu.rd(16'h0003, v1);
            mcu.rd(16'h0003, v2);
            check("prog_status", {~d[7], 7'h08}, v1 & 8'hBF);
            check("toggle", {7'h00, ~v1[6]}, {7'h00, v2[6]});
            wait_until(1'b0);
            rd_chk("prog_data", 16'h0003, d);
            rd_chk("prog_again", 16'h0003, d);
        end
        for (int k = 0; k < 2; k++) begin
            drive(8'h00, 4'h1, 12'h000, k[0]);
            prog(k ? 16'h0004 : 16'h0003, k ? 8'h00 : 8'hFF);
            settle(PCYC + 4);
            check("fail_set", 8'h03, {6'h00, failure_flag, busy});
            mcu.rd(16'h0003, v1);
            check("fail_status", 8'h20, v1 & 8'h20);
            mcu.wr(16'h0000, `CMD_UNLOCK2);
            settle(1);
            check("fail_hold", 8'h01, {7'h00, failure_flag});
            mcu.wr(16'h0000, `CMD_RESET);
            settle(1);
            check("fail_clear", 8'h00, {6'h00, failure_flag, busy});
        end
        drive(8'h00, 4'h1, 12'h000, 1'b0);
        rd_chk("bits_clear_only", 16'h0003, 8'h81);
        drive(8'h01, 4'h0, 12'h001, 1'b0);
        prog(16'h0004, 8'h00);
        wait_until(1'b0);
        check("prot_prog_busy", 8'h01, n[7:0]);
        rd_chk("prot_prog_data", 16'h0004, `ERASED_BYTE);
        drive(8'h01, 4'h0, 12'h000, 1'b0);
        erase(16'h0000, `CMD_SECTOR_ERASE);
        mcu.rd(16'h0003, v1);
        check("window_status", 8'h00, v1 & 8'h88);
        settle(1000);
        mcu.wr(16'h0000, `CMD_SECTOR_ERASE);
        wait_until(1'b1);
        check("window_len", 8'h01, {7'h00, n >= 2495 && n <= 3000});
        wait_until(1'b0);
        rd_chk("sector_erased", 16'h0003, `ERASED_BYTE);
        drive(8'h02, 4'h0, 12'h000, 1'b0);
        prog(16'h0002, 8'h00);
        wait_until(1'b0);
        drive(8'h02, 4'h0, 12'h002, 1'b0);
        erase(16'h0002, `CMD_SECTOR_ERASE);
        // the protected set is only known once the window has run out
        wait_until(1'b1);
        check("prot_window", 8'h01, {7'h00, n >= 2495 && n <= 3000});
        mcu.rd(16'h0002, v1);
        mcu.rd(16'h0002, v2);
        check("prot_erase_st", 8'h00, (v1 | v2) & 8'hC0);
        wait_until(1'b0);
        check("prot_erase_len", 8'h01, {7'h00, n >= 2400 && n <= 3000});
        rd_chk("prot_erase_data", 16'h0002, 8'h00);
        drive(8'h04, 4'h0, 12'h000, 1'b0);
        mcu.unlock();
        mcu.wr(16'h0555, `CMD_BYPASS);
        mcu.wr(16'h0000, `CMD_PROGRAM);
        mcu.wr(16'h0007, 8'h3C);
        wait_until(1'b0);
        rd_chk("fast_prog", 16'h0007, 8'h3C);
        mcu.wr(16'h0555, `CMD_ERASE_SETUP);
        mcu.wr(16'h0000, `CMD_BYPASS_EXIT1);
        mcu.wr(16'h0000, 8'h55);
        mcu.wr(16'h0000, `CMD_PROGRAM);
        mcu.wr(16'h0008, 8'hC3);
        wait_until(1'b0);
        rd_chk("fast_invalid", 16'h0008, 8'hC3);
        mcu.wr(16'h0001, `CMD_BYPASS_EXIT1);
        mcu.wr(16'h0002, `CMD_BYPASS_EXIT2);
        mcu.wr(16'h0000, `CMD_PROGRAM);
        mcu.wr(16'h0009, 8'h00);
        wait_until(1'b0);
        check("fast_exit_busy", 8'h01, n[7:0]);
        rd_chk("fast_exit_data", 16'h0009, `ERASED_BYTE);
        end_of_test();
    end

    initial begin
        #(40 * 30000);
        failures++;
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
